// [logic/scp_defs.vh]
// Constants for the system clock prescaler: register map, fields, timing.
// Assumes inclusion by the prescaler design files only.
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SCP_CTRL_OFFSET      12'h000
`define SCP_STATUS_OFFSET    12'h004

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SCP_UNLOCK_BIT       7
`define SCP_RSVD_MSB         6
`define SCP_RSVD_LSB         4
`define SCP_SEL_MSB          3
`define SCP_SEL_LSB          0
`define SCP_UNLOCK_PATTERN   8'h80
`define SCP_SEL_RESET_PLAIN  4'h0
`define SCP_SEL_RESET_DIV8   4'h3
`define SCP_SEL_MAX          4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCP_UNLOCK_CYCLES    3'h4
`define SCP_FUSE_SETTLE      2'h3

`endif

// [logic/scp_divider.v]
// Glitch-free power-of-two divider producing a clock enable and clock level.
// Assumes select is static or changes only at any cycle; switch is deferred.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.vh"

module scp_divider
(
    input  wire       pclk,
    input  wire       presetn,
    input  wire [3:0] sel,
    output reg        clk_en,
    output reg        clk_div,
    output reg  [3:0] active_sel
);

    reg [7:0] cnt_reg;
    reg [7:0] cnt_next;
    wire [7:0] last_cnt;

    // ----------------------------------------------------------------
    // Count window ends at 2^sel - 1
    // ----------------------------------------------------------------
    assign last_cnt = (8'h01 << active_sel[2:0]) - 8'h01 | {8{active_sel[3]}};

    always @*
    begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == last_cnt)
        begin
            cnt_next = 8'h00;
        end
    end

    // New factor only taken at the end of a full period, so no short pulse
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg    <= 8'h00;
            clk_en     <= 1'b0;
            clk_div    <= 1'b0;
            active_sel <= 4'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            clk_en  <= (cnt_reg == last_cnt);
            clk_div <= (active_sel == 4'h0) ? ~clk_div :
                       (cnt_next > (last_cnt >> 1));
            if (cnt_reg == last_cnt)
            begin
                active_sel <= sel;
                cnt_reg    <= 8'h00;
            end
        end
    end

endmodule // scp_divider

`default_nettype wire

// [logic/scp_prescaler.v]
// System clock prescaler: APB control register with timed unlock, and divider.
// Assumes pclk is the undivided source clock and presetn the system reset.
//
// Functional notes
// - Unlock bit sets only on a write of exactly 0x80 to the control register.
// - Unlock bit clears four cycles after set, or on a select write.
// - Rewriting unlock while it runs neither restarts nor clears the window.
// - Select field accepts writes only while unlock bit is set.
// - Bits 6 to 4 are reserved and read as zero.
// - Select 0..8 divides by two to the select; 9..15 reserved.
// - Select resets to 0000, or 0011 when the divide-by-eight fuse is set.
// - Any select value may be written after reset, whatever the fuse.
// - Division drives the system clock and may change at run time.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.vh"

module scp_prescaler
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        start_divide_by_eight_fuse,
    output reg         sys_clk_en,
    output reg         sys_clk
);

    // ----------------------------------------------------------------
    // Fuse synchroniser and reset capture
    // ----------------------------------------------------------------
    reg        fuse_s1_reg;
    reg        fuse_s2_reg;
    reg        fuse_s3_reg;
    reg        fuse_loaded_reg;
    reg [1:0]  fuse_wait_reg;
    wire       fuse_agree;
    reg        unlock_reg;
    reg [2:0]  unlock_cnt_reg;
    reg [3:0]  division_select_bits;
    reg [3:0]  select_next;
    reg        unlock_next;
    reg [2:0]  unlock_cnt_next;
    wire       div_en;
    wire       div_clk;
    wire [3:0] div_active;
    wire       wr_access;
    wire       rd_access;
    wire       hit_ctrl;
    wire       hit_status;
    wire [7:0] wbyte;

    function [3:0] clamp_sel;
        input [3:0] v;
        begin
            // Reserved codes fall back to the largest factor, the safe side
            clamp_sel = (v > `SCP_SEL_MAX) ? `SCP_SEL_MAX : v;
        end
    endfunction

    // The fuse is a static strap; it is caught after reset release
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fuse_s1_reg   <= 1'b0;
            fuse_s2_reg   <= 1'b0;
            fuse_s3_reg   <= 1'b0;
            fuse_wait_reg <= 2'h0;
        end
        else
        begin
            fuse_s1_reg <= start_divide_by_eight_fuse;
            fuse_s2_reg <= fuse_s1_reg;
            fuse_s3_reg <= fuse_s2_reg;
            // Reset values still in the chain must not count as agreement
            if (fuse_wait_reg != `SCP_FUSE_SETTLE)
            begin
                fuse_wait_reg <= fuse_wait_reg + 2'h1;
            end
        end
    end

    assign fuse_agree = (fuse_wait_reg == `SCP_FUSE_SETTLE) && (fuse_s2_reg == fuse_s3_reg);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign wr_access  = psel & penable & pwrite;
    assign rd_access  = psel & ~penable & ~pwrite;
    assign hit_ctrl   = (paddr == `SCP_CTRL_OFFSET);
    assign hit_status = (paddr == `SCP_STATUS_OFFSET);
    assign wbyte      = pstrb[0] ? pwdata[7:0] : 8'h00;

    // ----------------------------------------------------------------
    // Unlock window and select field
    // ----------------------------------------------------------------
    always @*
    begin
        select_next     = division_select_bits;
        unlock_next     = unlock_reg;
        unlock_cnt_next = unlock_cnt_reg;
        if (unlock_reg)
        begin
            unlock_cnt_next = unlock_cnt_reg - 3'h1;
            if (unlock_cnt_reg == 3'h1)
            begin
                unlock_next = 1'b0;
            end
        end
        if (wr_access && hit_ctrl && pstrb[0])
        begin
            if (wbyte == `SCP_UNLOCK_PATTERN)
            begin
                if (!unlock_reg)
                begin
                    unlock_next     = 1'b1;
                    unlock_cnt_next = `SCP_UNLOCK_CYCLES;
                end
                // A repeat unlock keeps the running window untouched
            end
            else if (unlock_reg && !wbyte[`SCP_UNLOCK_BIT])
            begin
                select_next     = clamp_sel(wbyte[3:0]);
                unlock_next     = 1'b0;
                unlock_cnt_next = 3'h0;
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fuse_loaded_reg      <= 1'b0;
            unlock_reg           <= 1'b0;
            unlock_cnt_reg       <= 3'h0;
            division_select_bits <= `SCP_SEL_RESET_DIV8;
        end
        else if (!fuse_loaded_reg)
        begin
            // Select holds divide-by-eight until the strap is known; only the divider's first cycle after reset runs at divide-by-one
            fuse_loaded_reg <= fuse_agree;
            if (fuse_agree)
            begin
                division_select_bits <= fuse_s3_reg ? `SCP_SEL_RESET_DIV8
                                                    : `SCP_SEL_RESET_PLAIN;
            end
        end
        else
        begin
            unlock_reg           <= unlock_next;
            unlock_cnt_reg       <= unlock_cnt_next;
            division_select_bits <= select_next;
        end
    end

    // ----------------------------------------------------------------
    // Read path, one wait-free access phase
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_ctrl & ~hit_status;
            if (rd_access && hit_ctrl)
            begin
                prdata <= {24'h00_0000, unlock_reg, 3'h0, division_select_bits};
            end
            else if (rd_access && hit_status)
            begin
                prdata <= {28'h000_0000, div_active};
            end
            else if (rd_access)
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Divider and system clock outputs
    // ----------------------------------------------------------------
    scp_divider u_divider
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .sel        (division_select_bits),
        .clk_en     (div_en),
        .clk_div    (div_clk),
        .active_sel (div_active)
    );

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_clk_en <= 1'b0;
            sys_clk    <= 1'b0;
        end
        else
        begin
            sys_clk_en <= div_en;
            sys_clk    <= div_clk;
        end
    end

endmodule // scp_prescaler

`default_nettype wire

// [tb/scp_prescaler_chk.sv]
// Port checker for the clock prescaler.
// Assumes a bind onto scp_prescaler, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module scp_prescaler_chk
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sys_clk_en
);
    logic [9:0] gap_reg;
    logic       seen_reg;
    wire        done = psel && penable && pready;
    wire        rd_ctl = done && !pwrite && paddr == 12'h000;
    wire        mapped = paddr == 12'h000 || paddr == 12'h004;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // First gap after reset is partial, so it is skipped
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            gap_reg <= 10'h001;
            seen_reg <= 1'b0;
        end
        else if (sys_clk_en)
        begin
            gap_reg <= 10'h001;
            seen_reg <= 1'b1;
        end
        else if (gap_reg != 10'h3FF)
            gap_reg <= gap_reg + 10'h001;
    property p_rsvd; rd_ctl |-> prdata[6:4] == 3'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_high; rd_ctl |-> prdata[31:8] == 24'h000000; endproperty
    a_high: assert property (p_high) else $error("upper bits set");
    property p_sel; rd_ctl |-> prdata[3:0] <= 4'h8; endproperty
    a_sel: assert property (p_sel) else $error("select above 8");
    property p_err; done && !mapped |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on hole");
    property p_ok; done && mapped |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on register");
    property p_rst; $rose(presetn) |-> !pready && !sys_clk_en; endproperty
    a_rst: assert property (p_rst) else $error("outputs live at reset");
    property p_pow; seen_reg && sys_clk_en |-> (gap_reg & (gap_reg - 10'h001)) == 10'h000;
    endproperty
    a_pow: assert property (p_pow) else $error("partial clock period");
    property p_gmax; seen_reg |-> gap_reg <= 10'h100; endproperty
    a_gmax: assert property (p_gmax) else $error("clock period too long");
endmodule // scp_prescaler_chk

bind scp_prescaler scp_prescaler_chk scp_prescaler_chk_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_clk_en(sys_clk_en)
);
`default_nettype wire

// [tb/test_scp_prescaler.sv]
// Self-checking bench for the system clock prescaler.
// Assumes a zero-wait APB slave with control at 0x000, status at 0x004.
`timescale 1ns/1ps
`default_nettype none
module test_scp_prescaler;
    localparam logic [11:0] CTL = 12'h000;
    localparam logic [11:0] STA = 12'h004;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        fuse = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sys_clk_en;
    logic        sys_clk;
    logic [31:0] rd;
    logic        er;
    logic [3:0]  s;
    logic [3:0]  x;
    int          n;
    int          h;
    int          bad_count = 0;
    int          n_checks = 0;

    always #12.5 pclk = ~pclk;

    scp_prescaler scp_prescaler_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .start_divide_by_eight_fuse(fuse), .sys_clk_en(sys_clk_en), .sys_clk(sys_clk)
    );

    // --------
    // Tasks
    // --------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Leading spare edge: a new setup never lands on the release edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic period(output int c, output int hi);
        int t;
        t = 0;
        hi = 0;
        @(posedge pclk);
        while (sys_clk_en !== 1'b1 && t < 600)
        begin
            @(posedge pclk);
            t++;
        end
        c = 0;
        do
        begin
            @(posedge pclk);
            c++;
            hi += (sys_clk === 1'b1);
        end
        while (sys_clk_en !== 1'b1 && c < 600);
    endtask

    task automatic rst(input logic f);
        @(posedge pclk);
        presetn <= 1'b0;
        fuse <= f;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    task automatic tally_and_finish;
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // --------
    // Tests
    // --------
    initial
    begin
        rst(1'b1);
        apb(1'b0, CTL, 32'h0);
        chk("fuse reset", rd, 32'h03);
        apb(1'b1, CTL, 32'h80);
        apb(1'b1, CTL, 32'h00);
        apb(1'b0, CTL, 32'h0);
        chk("over fuse", rd, 32'h00);
        rst(1'b0);
        apb(1'b0, CTL, 32'h0);
        chk("plain reset", rd, 32'h00);
        apb(1'b1, CTL, 32'h05);
        apb(1'b1, CTL, 32'h81);
        apb(1'b1, CTL, 32'h05);
        apb(1'b0, CTL, 32'h0);
        chk("locked", rd, 32'h00);
        apb(1'b1, CTL, 32'h80);
        apb(1'b0, CTL, 32'h0);
        chk("unlocked", rd, 32'h80);
        repeat (8) @(posedge pclk);
        apb(1'b1, CTL, 32'h02);
        apb(1'b0, CTL, 32'h0);
        chk("expired", rd, 32'h00);
        apb(1'b1, CTL, 32'h80);
        apb(1'b1, CTL, 32'h80);
        @(posedge pclk);
        apb(1'b0, CTL, 32'h0);
        chk("no restart", rd, 32'h00);
        apb(1'b1, 12'h008, 32'h80);
        chk("hole error", er, 1'b1);
        for (int k = 0; k < 10; k++)
        begin
            s = (k == 9) ? 4'hC : 4'(k);
            x = (k == 9) ? 4'h8 : 4'(k);
            apb(1'b1, CTL, 32'h80);
            apb(1'b1, CTL, {28'h0, s});
            apb(1'b0, CTL, 32'h0);
            chk("select", rd, {28'h0, x});
            period(n, h);
            period(n, h);
            chk("period", n, 32'h1 << x);
            if (k != 0) chk("duty", h, (32'h1 << x) >> 1);
            apb(1'b0, STA, 32'h0);
            chk("active", rd[3:0], x);
        end
        tally_and_finish;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        tally_and_finish;
    end
endmodule // test_scp_prescaler
`default_nettype wire
